/* design/interrupt_security_partition.sv */
// Purpose: security partitioning of an interrupt controller cpu interface
// Assumes: one processor interface, eight interrupts, accesses tagged secure or not
// Notes: registers are reached by select lines, reads answer combinationally
`include "isp_regs.svh"
//
// Contract
// - the type register shows a read-only flag saying security partitioning exists.
// - group 0 interrupts are secure and group 1 interrupts non-secure.
// - banked registers keep separate secure and non-secure copies.
// - the non-secure binary point copy is also reached by an alias that answers secure only.
// - secure accesses may read and change every configuration item.
// - alias acknowledge lets secure accesses handle group 1 interrupts.
// - the legacy acknowledge bit lets secure acknowledges take group 1 without the alias.
// - non-secure accesses cannot change group 0 state unless granted.
// - secure-written grant bits give non-secure accesses control over chosen group 0 irqs.
// - the group reset value is a build-time choice, allowing group 1 on reset.
// - with mask bit 7 zero, non-secure mask reads give zero and writes are ignored.
// - secure accesses may give a secure interrupt a low-half priority.
// - cooperative or not, no priority scheme is forced.
// - a non-secure priority write stores bit 7 set.
// - a smaller priority value is more urgent.
module interrupt_security_partition #(
    parameter logic [7:0] GROUP_RESET = `ISP_GROUP_RESET
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic acc_ns,
    input wire isp_pkg::sel_t acc_sel,
    input wire logic [2:0] acc_idx,
    input wire logic [7:0] acc_wdata,
    output logic [15:0] acc_rdata,
    input wire logic ack_req,
    input wire logic ack_alias,
    input wire logic ack_ns,
    output logic [3:0] ack_id,
    input wire logic [7:0] irq_pending,
    output logic [7:0] controller_type_reg,
    output logic irq_secure,
    output logic irq_nonsecure
);
    logic [7:0] group;
    logic [7:0] grant;
    logic [7:0] pmr;
    logic [2:0] bpr_s;
    logic [2:0] bpr_ns;
    logic ack_ctl;
    logic [7:0] active;
    logic [7:0] next_group;
    logic [7:0] next_grant;
    logic [7:0] next_pmr;
    logic [2:0] next_bpr_s;
    logic [2:0] next_bpr_ns;
    logic next_ack_ctl;
    logic [7:0] next_active;
    logic [3:0] next_ack_id;
    logic [7:0] prio [`ISP_NUM_IRQ];
    logic [7:0] view [`ISP_NUM_IRQ];
    logic [7:0] prio_wr;
    logic wr;
    logic pmr_hidden;
    logic [3:0] best_id;
    logic [7:0] best_prio;
    logic best_g1;
    // ==========================================
    // identification
    assign controller_type_reg = 8'h04;
    assign wr = acc_valid & acc_write;
    assign pmr_hidden = acc_ns & ~pmr[7];
    // ==========================================
    // priority fields
    genvar gi;
    generate
        for (gi = 0; gi < `ISP_NUM_IRQ; gi++) begin : g_slot
            assign prio_wr[gi] = wr && acc_sel == isp_pkg::SEL_PRIO
                && acc_idx == 3'(gi);
            isp_prio_slot u_slot (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .wr_en(prio_wr[gi]),
                .wr_ns(acc_ns),
                .group1(group[gi]),
                .ns_granted(grant[gi]),
                .wr_data(acc_wdata),
                .rd_ns(acc_ns),
                .prio(prio[gi]),
                .view(view[gi])
            );
        end
    endgenerate
    // ==========================================
    // configuration writes
    always_comb begin
        next_group = group;
        next_grant = grant;
        next_pmr = pmr;
        next_bpr_s = bpr_s;
        next_bpr_ns = bpr_ns;
        next_ack_ctl = ack_ctl;
        if (wr) begin
            if (acc_sel == isp_pkg::SEL_GROUP && !acc_ns) begin
                next_group = acc_wdata;
            end else if (acc_sel == isp_pkg::SEL_GRANT && !acc_ns) begin
                next_grant = acc_wdata;
            end else if (acc_sel == isp_pkg::SEL_PMR) begin
                if (!acc_ns) begin
                    next_pmr = acc_wdata;
                end else if (!pmr_hidden) begin
                    next_pmr = {1'b1, acc_wdata[7:1]};
                end
            end else if (acc_sel == isp_pkg::SEL_BPR) begin
                if (acc_ns) begin
                    next_bpr_ns = acc_wdata[2:0];
                end else begin
                    next_bpr_s = acc_wdata[2:0];
                end
            end else if (acc_sel == isp_pkg::SEL_ABPR && !acc_ns) begin
                next_bpr_ns = acc_wdata[2:0];
            end else if (acc_sel == isp_pkg::SEL_CTRL && !acc_ns) begin
                next_ack_ctl = acc_wdata[0];
            end
        end
    end
    // ==========================================
    // read mux
    always_comb begin
        acc_rdata = 16'h0000;
        if (acc_valid && !acc_write) begin
            if (acc_sel == isp_pkg::SEL_GROUP) begin
                acc_rdata = {8'h00, acc_ns ? 8'h00 : group};
            end else if (acc_sel == isp_pkg::SEL_GRANT) begin
                acc_rdata = {8'h00, acc_ns ? 8'h00 : grant};
            end else if (acc_sel == isp_pkg::SEL_PRIO) begin
                acc_rdata = {8'h00, view[acc_idx]};
            end else if (acc_sel == isp_pkg::SEL_PMR) begin
                if (!acc_ns) begin
                    acc_rdata = {8'h00, pmr};
                end else if (!pmr_hidden) begin
                    acc_rdata = {8'h00, pmr[6:0], 1'b0};
                end
            end else if (acc_sel == isp_pkg::SEL_BPR) begin
                acc_rdata = {13'h0000, acc_ns ? bpr_ns : bpr_s};
            end else if (acc_sel == isp_pkg::SEL_ABPR) begin
                acc_rdata = {13'h0000, acc_ns ? 3'h0 : bpr_ns};
            end else if (acc_sel == isp_pkg::SEL_CTRL) begin
                acc_rdata = {15'h0000, acc_ns ? 1'b0 : ack_ctl};
            end else if (acc_sel == isp_pkg::SEL_NONE) begin
                acc_rdata = {8'h00, controller_type_reg};
            end
        end
    end
    // ==========================================
    // highest pending selection
    always_comb begin
        best_id = `ISP_SPURIOUS;
        best_prio = 8'hFF;
        best_g1 = 1'b0;
        for (int i = 0; i < `ISP_NUM_IRQ; i++) begin
            if (irq_pending[i] && !active[i] && prio[i] < pmr
                && (best_id == `ISP_SPURIOUS || prio[i] < best_prio)) begin
                best_id = 4'(i);
                best_prio = prio[i];
                best_g1 = group[i];
            end
        end
    end
    assign irq_secure = best_id != `ISP_SPURIOUS && !best_g1;
    assign irq_nonsecure = best_id != `ISP_SPURIOUS && best_g1;
    // ==========================================
    // acknowledge
    always_comb begin
        next_active = active;
        next_ack_id = ack_id;
        if (ack_req) begin
            next_ack_id = `ISP_SPURIOUS;
            if (best_id != `ISP_SPURIOUS) begin
                if ((ack_ns && best_g1) || (!ack_ns && !ack_alias && !best_g1)
                    || (!ack_ns && ack_alias && best_g1)
                    || (!ack_ns && !ack_alias && ack_ctl)) begin
                    next_ack_id = best_id;
                    next_active[best_id[2:0]] = 1'b1;
                end
            end
        end
    end
    // ==========================================
    // state registers
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            group <= GROUP_RESET;
            grant <= 8'h00;
            pmr <= `ISP_PMR_RESET;
            bpr_s <= `ISP_BPR_S_RESET;
            bpr_ns <= `ISP_BPR_NS_RESET;
            ack_ctl <= 1'b0;
            active <= 8'h00;
            ack_id <= `ISP_SPURIOUS;
        end else begin
            group <= next_group;
            grant <= next_grant;
            pmr <= next_pmr;
            bpr_s <= next_bpr_s;
            bpr_ns <= next_bpr_ns;
            ack_ctl <= next_ack_ctl;
            active <= next_active;
            ack_id <= next_ack_id;
        end
    end
    // ==========================================
    // checks
    a_ns_group_locked: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wr && acc_ns && acc_sel == isp_pkg::SEL_GROUP |=> $stable(group))
        else $error("non-secure write changed group");
    a_pmr_hidden_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
        acc_valid && !acc_write && acc_ns && acc_sel == isp_pkg::SEL_PMR && !pmr[7]
        |-> acc_rdata == 16'h0000)
        else $error("hidden mask visible");
    a_pmr_hidden_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wr && acc_ns && acc_sel == isp_pkg::SEL_PMR && !pmr[7] |=> $stable(pmr))
        else $error("hidden mask written");
    a_abpr_alias: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wr && !acc_ns && acc_sel == isp_pkg::SEL_ABPR |=> bpr_ns == $past(acc_wdata[2:0]))
        else $error("alias did not write non-secure copy");
    a_type_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
        controller_type_reg[2])
        else $error("security flag missing");
    a_ns_prio_top: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wr && acc_ns && acc_sel == isp_pkg::SEL_PRIO && group[acc_idx]
        |=> prio[$past(acc_idx)][7])
        else $error("non-secure priority lacks top bit");
    a_sec_prio_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wr && !acc_ns && acc_sel == isp_pkg::SEL_PRIO
        |=> prio[$past(acc_idx)] == $past(acc_wdata))
        else $error("secure priority write lost");
    a_signal_group: assert property (@(posedge clk_sys) disable iff (sys_rst)
        irq_nonsecure |-> group[best_id[2:0]] && !irq_secure)
        else $error("wrong group signalled");
    a_ns_ack_g0: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ack_req && ack_ns && irq_secure |=> ack_id == `ISP_SPURIOUS)
        else $error("non-secure acknowledged group 0");
    c_alias_ack: cover property (@(posedge clk_sys) ack_req && ack_alias && irq_nonsecure);
    c_ns_prio_wr: cover property (@(posedge clk_sys) wr && acc_ns && acc_sel == isp_pkg::SEL_PRIO);
    c_pmr_hidden: cover property (@(posedge clk_sys) pmr_hidden && acc_valid);
endmodule

/* design/isp_pkg.sv */
// Purpose: types for the interrupt security partition
// Assumes: nothing
// Notes: none
package isp_pkg;
    typedef enum logic [7:0] {
        SEL_NONE = 8'h01,
        SEL_GROUP = 8'h02,
        SEL_PRIO = 8'h04,
        SEL_PMR = 8'h08,
        SEL_BPR = 8'h10,
        SEL_ABPR = 8'h20,
        SEL_CTRL = 8'h40,
        SEL_GRANT = 8'h80
    } sel_t;
endpackage

/* design/isp_prio_slot.sv */
// Purpose: one interrupt's priority field with non-secure view filtering
// Assumes: group bit supplied by the owner
// Notes: none
`include "isp_regs.svh"
module isp_prio_slot (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic wr_ns,
    input wire logic group1,
    input wire logic ns_granted,
    input wire logic [7:0] wr_data,
    input wire logic rd_ns,
    output logic [7:0] prio,
    output logic [7:0] view
);
    logic [7:0] next_prio;
    logic ns_ok;
    assign ns_ok = group1 | ns_granted;
    always_comb begin
        next_prio = prio;
        if (wr_en) begin
            if (!wr_ns) begin
                next_prio = wr_data;
            end else if (ns_ok) begin
                next_prio = {1'b1, wr_data[7:1]};
            end
        end
    end
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            prio <= `ISP_PRIO_RESET;
        end else begin
            prio <= next_prio;
        end
    end
    // non-secure view is shifted left, group 0 hidden unless granted
    always_comb begin
        if (!rd_ns) begin
            view = prio;
        end else if (ns_ok) begin
            view = {prio[6:0], 1'b0};
        end else begin
            view = 8'h00;
        end
    end
endmodule

/* design/isp_regs.svh */
// Purpose: constants for the interrupt security partition
// Assumes: small fixed interrupt count, one processor interface
// Notes: none
`ifndef ISP_REGS_SVH
`define ISP_REGS_SVH
`define ISP_NUM_IRQ 8
`define ISP_IRQ_IDW 3
`define ISP_PRIO_TOP 7
`define ISP_GROUP_RESET 8'h00
`define ISP_PRIO_RESET 8'h00
`define ISP_PMR_RESET 8'h00
`define ISP_BPR_S_RESET 3'h2
`define ISP_BPR_NS_RESET 3'h3
`define ISP_TYPE_SEC_BIT 10
`define ISP_SGI_COUNT 2
`define ISP_SPURIOUS 4'h8
`endif

/* testbench/core_model.sv */
// Purpose: processor model issuing tagged register accesses and acknowledges
// Assumes: one request at a time
// Notes: requests launch on a rising edge and drop one cycle later
module core_model (
    input wire logic clk_sys,
    output logic acc_valid,
    output logic acc_write,
    output logic acc_ns,
    output isp_pkg::sel_t acc_sel,
    output logic [2:0] acc_idx,
    output logic [7:0] acc_wdata,
    output logic ack_req,
    output logic ack_alias,
    output logic ack_ns
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // idle levels
    initial begin
        acc_valid = 1'h0;
        acc_write = 1'h0;
        acc_ns = 1'h0;
        acc_sel = isp_pkg::SEL_NONE;
        acc_idx = 3'h0;
        acc_wdata = 8'h00;
        ack_req = 1'h0;
        ack_alias = 1'h0;
        ack_ns = 1'h0;
    end
    // ==========================================
    // requests
    task automatic acc(input logic w, input logic ns, input isp_pkg::sel_t s,
                       input logic [2:0] i, input logic [7:0] d);
        @(posedge clk_sys);
        acc_valid <= 1'h1;
        acc_write <= w;
        acc_ns <= ns;
        acc_sel <= s;
        acc_idx <= i;
        acc_wdata <= d;
        @(posedge clk_sys);
        acc_valid <= 1'h0;
        acc_wdata <= ~d;
    endtask
    // acknowledge request, secure or non-secure, with or without the alias
    task automatic ack(input logic use_alias, input logic ns);
        @(posedge clk_sys);
        ack_req <= 1'h1;
        ack_alias <= use_alias;
        ack_ns <= ns;
        @(posedge clk_sys);
        ack_req <= 1'h0;
    endtask
endmodule

/* testbench/tb.sv */
// Purpose: self-checking bench for the interrupt security partition
// Assumes: reads answer in the access cycle, acknowledge id one edge later
// Notes: expected results queue in order and a monitor pops them
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic is_ack; logic [15:0] v;} note_t;
    logic clk_sys, sys_rst, acc_valid, acc_write, acc_ns, ack_req, ack_alias, ack_ns;
    logic irq_secure, irq_nonsecure, ack_wait;
    isp_pkg::sel_t acc_sel;
    logic [2:0] acc_idx;
    logic [7:0] acc_wdata, irq_pending, controller_type_reg, r;
    logic [15:0] acc_rdata;
    logic [3:0] ack_id;
    note_t exp_q[$];
    int n_mismatch, checks;
    core_model i_core (.clk_sys(clk_sys), .acc_valid(acc_valid), .acc_write(acc_write),
        .acc_ns(acc_ns), .acc_sel(acc_sel), .acc_idx(acc_idx), .acc_wdata(acc_wdata),
        .ack_req(ack_req), .ack_alias(ack_alias), .ack_ns(ack_ns));
    interrupt_security_partition i_interrupt_security_partition (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .acc_valid(acc_valid), .acc_write(acc_write), .acc_ns(acc_ns),
        .acc_sel(acc_sel), .acc_idx(acc_idx), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
        .ack_req(ack_req), .ack_alias(ack_alias), .ack_ns(ack_ns), .ack_id(ack_id),
        .irq_pending(irq_pending), .controller_type_reg(controller_type_reg),
        .irq_secure(irq_secure), .irq_nonsecure(irq_nonsecure));
    // ==========================================
    // compare tasks
    task automatic cmp_note(input logic k, input logic [15:0] got);
        note_t n;
        checks++;
        if (exp_q.size() != 0) begin
            n = exp_q.pop_front();
        end else begin
            n = {~k, ~got};
        end
        if (n.is_ack !== k || n.v !== got) begin
            n_mismatch++;
            $display("unexpected result at %0t got %h expected %h", $time, got, n.v);
        end
    endtask
    task automatic cmp_lvl(input logic [7:0] got, input logic [7:0] e);
        checks++;
        if (got !== e) begin
            n_mismatch++;
            $display("unexpected level at %0t got %h expected %h", $time, got, e);
        end
    endtask
    // ==========================================
    // drivers
    task automatic wr(input logic ns, input isp_pkg::sel_t s, input logic [2:0] i,
                      input logic [7:0] d);
        i_core.acc(1'h1, ns, s, i, d);
    endtask
    task automatic rd(input logic ns, input isp_pkg::sel_t s, input logic [2:0] i,
                      input logic [15:0] e);
        exp_q.push_back({1'h0, e});
        i_core.acc(1'h0, ns, s, i, 8'h00);
    endtask
    task automatic ak(input logic al, input logic ns, input logic [3:0] e);
        exp_q.push_back({1'h1, 12'h000, e});
        i_core.ack(al, ns);
    endtask
    task automatic lv(input logic [7:0] p, input logic [1:0] e);
        @(posedge clk_sys);
        irq_pending <= p;
        @(negedge clk_sys);
        cmp_lvl({6'h00, irq_secure, irq_nonsecure}, {6'h00, e});
    endtask
    task automatic tally_and_finish;
        if (exp_q.size() != 0) n_mismatch++;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ==========================================
    // clock, monitor, watchdog
    initial begin
        clk_sys = 1'h0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (ack_wait === 1'h1) cmp_note(1'h1, {12'h000, ack_id});
        ack_wait = ack_req;
        if (acc_valid === 1'h1 && acc_write === 1'h0) cmp_note(1'h0, acc_rdata);
    end
    initial begin
        repeat (2000) @(posedge clk_sys);
        n_mismatch++;
        tally_and_finish();
    end
    // ==========================================
    // main sequence
    initial begin
        sys_rst = 1'h1;
        irq_pending = 8'h00;
        ack_wait = 1'h0;
        n_mismatch = 0;
        checks = 0;
        void'($urandom(26));
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'h0;
        cmp_lvl(controller_type_reg, 8'h04);
        rd(1'h0, isp_pkg::SEL_GROUP, 3'h0, 16'h0000);
        rd(1'h0, isp_pkg::SEL_BPR, 3'h0, 16'h0002);
        rd(1'h1, isp_pkg::SEL_BPR, 3'h0, 16'h0003);
        rd(1'h0, isp_pkg::SEL_ABPR, 3'h0, 16'h0003);
        rd(1'h1, isp_pkg::SEL_ABPR, 3'h0, 16'h0000);
        wr(1'h0, isp_pkg::SEL_BPR, 3'h0, 8'h05);
        wr(1'h1, isp_pkg::SEL_BPR, 3'h0, 8'h01);
        rd(1'h0, isp_pkg::SEL_BPR, 3'h0, 16'h0005);
        rd(1'h0, isp_pkg::SEL_ABPR, 3'h0, 16'h0001);
        wr(1'h0, isp_pkg::SEL_ABPR, 3'h0, 8'h06);
        rd(1'h1, isp_pkg::SEL_BPR, 3'h0, 16'h0006);
        wr(1'h1, isp_pkg::SEL_GROUP, 3'h0, 8'hff);
        rd(1'h0, isp_pkg::SEL_GROUP, 3'h0, 16'h0000);
        wr(1'h0, isp_pkg::SEL_GROUP, 3'h0, 8'hf0);
        rd(1'h0, isp_pkg::SEL_GROUP, 3'h0, 16'h00f0);
        wr(1'h0, isp_pkg::SEL_PMR, 3'h0, 8'h70);
        rd(1'h1, isp_pkg::SEL_PMR, 3'h0, 16'h0000);
        wr(1'h1, isp_pkg::SEL_PMR, 3'h0, 8'hff);
        rd(1'h0, isp_pkg::SEL_PMR, 3'h0, 16'h0070);
        r = 8'($urandom);
        wr(1'h1, isp_pkg::SEL_PRIO, 3'h5, r);
        rd(1'h0, isp_pkg::SEL_PRIO, 3'h5, {8'h00, 1'h1, r[7:1]});
        rd(1'h1, isp_pkg::SEL_PRIO, 3'h5, {8'h00, r[7:1], 1'h0});
        wr(1'h1, isp_pkg::SEL_PRIO, 3'h1, r);
        rd(1'h0, isp_pkg::SEL_PRIO, 3'h1, 16'h0000);
        rd(1'h1, isp_pkg::SEL_PRIO, 3'h1, 16'h0000);
        wr(1'h1, isp_pkg::SEL_GRANT, 3'h0, 8'hff);
        wr(1'h0, isp_pkg::SEL_GRANT, 3'h0, 8'h02);
        rd(1'h0, isp_pkg::SEL_GRANT, 3'h0, 16'h0002);
        rd(1'h1, isp_pkg::SEL_GRANT, 3'h0, 16'h0000);
        wr(1'h1, isp_pkg::SEL_PRIO, 3'h1, r);
        rd(1'h0, isp_pkg::SEL_PRIO, 3'h1, {8'h00, 1'h1, r[7:1]});
        rd(1'h1, isp_pkg::SEL_PRIO, 3'h1, {8'h00, r[7:1], 1'h0});
        wr(1'h0, isp_pkg::SEL_PRIO, 3'h6, 8'h30);
        rd(1'h0, isp_pkg::SEL_PRIO, 3'h6, 16'h0030);
        wr(1'h0, isp_pkg::SEL_PRIO, 3'h2, 8'hc0);
        rd(1'h0, isp_pkg::SEL_PRIO, 3'h2, 16'h00c0);
        wr(1'h0, isp_pkg::SEL_PRIO, 3'h5, 8'he0);
        wr(1'h0, isp_pkg::SEL_PMR, 3'h0, 8'hf0);
        lv(8'h24, 2'h2);
        wr(1'h0, isp_pkg::SEL_PRIO, 3'h5, 8'h90);
        lv(8'h24, 2'h1);
        ak(1'h1, 1'h0, 4'h5);
        lv(8'h24, 2'h2);
        ak(1'h0, 1'h1, 4'h8);
        ak(1'h0, 1'h0, 4'h2);
        lv(8'h24, 2'h0);
        lv(8'h40, 2'h1);
        wr(1'h1, isp_pkg::SEL_CTRL, 3'h0, 8'h01);
        ak(1'h0, 1'h0, 4'h8);
        wr(1'h0, isp_pkg::SEL_CTRL, 3'h0, 8'h01);
        ak(1'h0, 1'h0, 4'h6);
        repeat (3) @(posedge clk_sys);
        tally_and_finish();
    end
endmodule
